/* rtl/mmuap_check.sv */
// Purpose: Access protection check for fetches, loads, stores and cache ops.
// Assumes: Core pipeline signals share sys_clk; Wishbone classic slave.
// Notes: Each check answers one cycle after its request.
//
// Summary of operation
// - Fetch checks only with instruction translation on, data checks with data.
// - Non-zero translation ID must equal the process ID low byte.
// - Zero translation ID matches every process; other checks still apply.
// - Fetch from non-executable page is tagged; executing it raises storage fault.
// - Tagged fetch that is discarded raises nothing.
// - Valid entry grants reads except under problem-state zone 00; writes follow write permit and zone.
// - Store without effective write permit raises data storage fault.
// - Four-bit zone select picks one of sixteen zone fields.
// - Zone n occupies big-endian bits 2n to 2n+1.
// - Problem state: 00 denies all, 01/10 use bits, 11 grants.
// - Supervisor state: 00/01 use bits, 10/11 grant execute and write.
// - Only problem-state zone 00 denies reads; supervisor loads with a qualified entry always pass.
// - Instruction block invalidate is checked as a load.
// - Under zone 00 only listed ops fault; allocate and touch become no-ops.
// - Under clear write permit only stores and data block invalidate, zero, congruence ops fault.
// - Block allocate becomes a no-op instead of faulting.
// - Touches become no-ops under zone 00; data touches never miss, instruction touch may.
// - Data congruence invalidate checks write permit on its operand.
// - Instruction congruence invalidate never faults but may miss.
// - String ops with zero count never fault or miss; store is no-op.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mmuap_check
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fch_valid,
    input wire logic fch_hit,
    input wire logic [7:0] fch_tid,
    input wire logic fch_ex,
    input wire logic [3:0] fch_zone_select_field,
    output logic fch_done_r,
    output logic [1:0] fch_tag_r,
    input wire logic exe_valid,
    input wire logic [1:0] exe_tag,
    output logic isi_r,
    output logic itlb_miss_r,
    input wire logic dat_valid,
    input wire mmuap_pkg::mmuap_op_type dat_op,
    input wire logic dat_hit,
    input wire logic [7:0] dat_tid,
    input wire logic dat_wr,
    input wire logic [3:0] dat_zone_select_field,
    input wire logic [6:0] string_byte_count,
    output logic dat_done_r,
    output logic dat_allow_r,
    output logic dat_noop_r,
    output logic dsi_r,
    output logic dtlb_miss_r
);
    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] process_id_reg_r;
    logic [31:0] zone_protection_reg_r;
    logic [2:0] ctrl_r;
    logic [mmuap_pkg::CNT_W-1:0] dsi_cnt_r;
    logic [mmuap_pkg::CNT_W-1:0] isi_cnt_r;
    logic [mmuap_pkg::CNT_W-1:0] miss_cnt_r;
    logic instr_translate_enable;
    logic data_translate_enable;
    logic problem_state_flag;
    logic wb_req;
    logic wb_wr;
    logic [31:0] rd_nxt;
    logic [31:0] pid_merge;

    assign instr_translate_enable = ctrl_r[mmuap_pkg::CTRL_ITE_BIT];
    assign data_translate_enable = ctrl_r[mmuap_pkg::CTRL_DTE_BIT];
    assign problem_state_flag = ctrl_r[mmuap_pkg::CTRL_PROB_BIT];
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;

    // Byte-lane merge shared by the process ID and zone protection registers.
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] din,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[8*i +: 8] = din[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign pid_merge = lane_merge(process_id_reg_r, wb_dat_i, wb_sel_i);

    // The ack lasts one cycle and masks the request while high, so a request held past its ack is taken again every second cycle.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
        end
    end

    // Only the low byte of the process ID exists; the rest reads zero.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            process_id_reg_r <= mmuap_pkg::PID_RESET;
        end
        else if (wb_wr && wb_adr_i == mmuap_pkg::OFS_PID)
        begin
            process_id_reg_r <= {24'h00_0000, pid_merge[7:0]};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            zone_protection_reg_r <= mmuap_pkg::ZPR_RESET;
        end
        else if (wb_wr && wb_adr_i == mmuap_pkg::OFS_ZPR)
        begin
            zone_protection_reg_r <=
                lane_merge(zone_protection_reg_r, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= mmuap_pkg::CTRL_RESET;
        end
        else if (wb_wr && wb_adr_i == mmuap_pkg::OFS_CTRL && wb_sel_i[0])
        begin
            ctrl_r <= wb_dat_i[2:0];
        end
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_comb
    begin
        unique case (wb_adr_i)
            mmuap_pkg::OFS_PID: rd_nxt = process_id_reg_r;
            mmuap_pkg::OFS_ZPR: rd_nxt = zone_protection_reg_r;
            mmuap_pkg::OFS_CTRL: rd_nxt = {29'h0000_0000, ctrl_r};
            mmuap_pkg::OFS_STAT:
                rd_nxt = {8'h00, miss_cnt_r, isi_cnt_r, dsi_cnt_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (wb_req)
        begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_nxt;
        end
    end

    // ****************************************
    // Fetch side
    // ****************************************
    logic f_entry_ok;
    logic f_deny;
    logic f_ex_ok;
    logic [1:0] f_tag;

    mmuap_id_match u_fid
    (
        .entry_hit(fch_hit),
        .translation_id_field(fch_tid),
        .process_id(process_id_reg_r[mmuap_pkg::PID_W-1:0]),
        .entry_ok(f_entry_ok)
    );

    mmuap_zone_perm u_fzone
    (
        .zone_protection_reg(zone_protection_reg_r),
        .zone_select_field(fch_zone_select_field),
        .problem_state_flag(problem_state_flag),
        .execute_permit_bit(fch_ex),
        .write_permit_bit(1'b0),
        .deny_all(f_deny),
        .ex_ok(f_ex_ok),
        .wr_ok()
    );

    always_comb
    begin
        f_tag = 2'h0;
        if (instr_translate_enable)
        begin
            if (!f_entry_ok)
            begin
                f_tag[mmuap_pkg::TAG_MISS_BIT] = 1'b1;
            end
            else if (f_deny || !f_ex_ok)
            begin
                f_tag[mmuap_pkg::TAG_PROT_BIT] = 1'b1;
            end
        end
    end

    // The tag rides with the instruction; faults wait for execution.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fch_done_r <= 1'b0;
            fch_tag_r <= 2'h0;
        end
        else
        begin
            fch_done_r <= fch_valid;
            fch_tag_r <= fch_valid ? f_tag : 2'h0;
        end
    end

    // A discarded instruction never shows up here, so it stays silent.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            isi_r <= 1'b0;
            itlb_miss_r <= 1'b0;
        end
        else
        begin
            itlb_miss_r <= exe_valid && exe_tag[mmuap_pkg::TAG_MISS_BIT];
            isi_r <= exe_valid && !exe_tag[mmuap_pkg::TAG_MISS_BIT] &&
                     exe_tag[mmuap_pkg::TAG_PROT_BIT];
        end
    end

    // ****************************************
    // Data side
    // ****************************************
    logic d_entry_ok;
    logic d_deny;
    logic d_wr_ok;
    logic d_wr_bad;
    logic d_str;
    logic d_dsi;
    logic d_miss;
    logic d_noop;
    mmuap_pkg::mmuap_attr_type d_attr;

    mmuap_id_match u_did
    (
        .entry_hit(dat_hit),
        .translation_id_field(dat_tid),
        .process_id(process_id_reg_r[mmuap_pkg::PID_W-1:0]),
        .entry_ok(d_entry_ok)
    );

    mmuap_zone_perm u_dzone
    (
        .zone_protection_reg(zone_protection_reg_r),
        .zone_select_field(dat_zone_select_field),
        .problem_state_flag(problem_state_flag),
        .execute_permit_bit(1'b0),
        .write_permit_bit(dat_wr),
        .deny_all(d_deny),
        .ex_ok(),
        .wr_ok(d_wr_ok)
    );

    assign d_attr = mmuap_pkg::op_attr(dat_op);
    // A denying zone must not turn a set write permit into a write fault.
    assign d_wr_bad = d_deny ? !dat_wr : !d_wr_ok;
    assign d_str = dat_op == mmuap_pkg::OP_STR_LOAD ||
                   dat_op == mmuap_pkg::OP_STR_STORE;

    // Reads need only a qualified entry; deny only comes from the zone.
    always_comb
    begin
        d_dsi = 1'b0;
        d_miss = 1'b0;
        d_noop = 1'b0;
        if (d_str && string_byte_count == 7'h00)
        begin
            d_noop = dat_op == mmuap_pkg::OP_STR_STORE;
        end
        else if (data_translate_enable)
        begin
            if (!d_entry_ok)
            begin
                d_miss = !d_attr.no_miss;
                d_noop = d_attr.no_miss;
            end
            else
            begin
                d_dsi = (d_deny && d_attr.z_fault) ||
                        (d_wr_bad && d_attr.w_fault);
                d_noop = !d_dsi && ((d_deny && d_attr.z_noop) ||
                                    (d_wr_bad && d_attr.w_noop));
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dat_done_r <= 1'b0;
            dat_allow_r <= 1'b0;
            dat_noop_r <= 1'b0;
            dsi_r <= 1'b0;
            dtlb_miss_r <= 1'b0;
        end
        else
        begin
            dat_done_r <= dat_valid;
            dat_allow_r <= dat_valid && !d_dsi && !d_miss && !d_noop;
            dat_noop_r <= dat_valid && d_noop;
            dsi_r <= dat_valid && d_dsi;
            dtlb_miss_r <= dat_valid && d_miss;
        end
    end

    // Wrapping event counters give software a view of fault activity.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dsi_cnt_r <= '0;
            isi_cnt_r <= '0;
            miss_cnt_r <= '0;
        end
        else
        begin
            dsi_cnt_r <= dsi_cnt_r + CNT_ONE(dsi_r);
            isi_cnt_r <= isi_cnt_r + CNT_ONE(isi_r);
            miss_cnt_r <= miss_cnt_r + CNT_ONE(dtlb_miss_r || itlb_miss_r);
        end
    end

    function automatic logic [mmuap_pkg::CNT_W-1:0] CNT_ONE(input logic b);
        return {{(mmuap_pkg::CNT_W-1){1'b0}}, b};
    endfunction

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_fetch_off_clean: assert property (
        fch_valid && !instr_translate_enable |=> fch_tag_r == 2'h0)
        else $error("fetch tagged with translation off");
    a_tid_mismatch_miss: assert property (
        dat_valid && data_translate_enable && dat_hit && !d_str &&
        dat_tid != 8'h00 && dat_tid != process_id_reg_r[7:0] &&
        !d_attr.no_miss |=> dtlb_miss_r && !dat_allow_r)
        else $error("foreign translation ID not refused");
    a_tid_zero_ok: assert property (
        dat_valid && data_translate_enable && dat_hit &&
        dat_tid == 8'h00 |=> !dtlb_miss_r)
        else $error("shared entry reported as miss");
    a_exec_isi: assert property (
        exe_valid && exe_tag == 2'h1 |=> isi_r ##1 !isi_r || $past(exe_valid))
        else $error("tagged execution did not fault");
    a_no_exec_quiet: assert property (
        !exe_valid |=> !isi_r && !itlb_miss_r)
        else $error("fault without execution attempt");
    a_store_wr_fault: assert property (
        dat_valid && data_translate_enable && d_entry_ok && !d_wr_ok &&
        dat_op == mmuap_pkg::OP_STORE |=> dsi_r && !dat_allow_r)
        else $error("store without write permit allowed");
    a_super_load_ok: assert property (
        dat_valid && d_entry_ok && !problem_state_flag &&
        dat_op == mmuap_pkg::OP_LOAD |=> dat_allow_r)
        else $error("supervisor load denied");
    a_alloc_quiet: assert property (
        dat_valid && dat_op == mmuap_pkg::OP_BLK_ALLOC |=> !dsi_r)
        else $error("allocate raised a storage fault");
    a_touch_no_miss: assert property (
        dat_valid && (dat_op == mmuap_pkg::OP_TOUCH ||
        dat_op == mmuap_pkg::OP_TOUCH_ST) |=> !dtlb_miss_r && !dsi_r)
        else $error("touch raised an interrupt");
    a_str_zero_quiet: assert property (
        dat_valid && d_str && string_byte_count == 7'h00
        |=> !dsi_r && !dtlb_miss_r)
        else $error("empty string op faulted");
    a_xlate_off_quiet: assert property (
        dat_valid && !data_translate_enable && !d_str
        |=> dat_allow_r && !dsi_r && !dtlb_miss_r)
        else $error("check active with translation off");

    c_store_fault: cover property (dat_valid ##1 dsi_r);
    c_fetch_prot: cover property (fch_valid ##1 fch_tag_r == 2'h1);
    c_touch_noop: cover property (dat_valid ##1 dat_noop_r);
    c_exec_fault: cover property (exe_valid ##1 isi_r);
endmodule
`default_nettype wire

/* rtl/mmuap_pkg.sv */
// Purpose: Shared constants and types of the access protection checker.
// Assumes: Register offsets are byte addresses on a 32-bit Wishbone bus.
// Notes: Zone fields use big-endian bit numbering, bit 0 is the MSB.
package mmuap_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_PID = 8'h00;
    localparam logic [7:0] OFS_ZPR = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [31:0] PID_RESET = 32'h0000_0000;
    localparam logic [31:0] ZPR_RESET = 32'h0000_0000;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int PID_W = 8;
    localparam int CTRL_ITE_BIT = 0;
    localparam int CTRL_DTE_BIT = 1;
    localparam int CTRL_PROB_BIT = 2;
    localparam int CNT_W = 8;
    localparam int TBC_W = 7;

    // ****************************************
    // Zone encodings
    // ****************************************
    localparam logic [1:0] ZONE_DENY = 2'h0;
    localparam logic [1:0] ZONE_FULL = 2'h3;

    // ****************************************
    // Fetch error tag carried with a prefetched instruction
    // ****************************************
    localparam int TAG_PROT_BIT = 0;
    localparam int TAG_MISS_BIT = 1;

    // ****************************************
    // Data side operation kinds
    // ****************************************
    typedef enum logic [4:0] {
        OP_LOAD = 5'h00,
        OP_STORE = 5'h01,
        OP_BLK_ALLOC = 5'h02,
        OP_BLK_FLUSH = 5'h03,
        OP_BLK_INVAL = 5'h04,
        OP_BLK_STBACK = 5'h05,
        OP_TOUCH = 5'h06,
        OP_TOUCH_ST = 5'h07,
        OP_BLK_ZERO = 5'h08,
        OP_DC_CC_INVAL = 5'h09,
        OP_DC_READ = 5'h0A,
        OP_IC_BLK_INVAL = 5'h0B,
        OP_IC_TOUCH = 5'h0C,
        OP_IC_CC_INVAL = 5'h0D,
        OP_IC_READ = 5'h0E,
        OP_STR_LOAD = 5'h0F,
        OP_STR_STORE = 5'h10
    } mmuap_op_type;

    typedef struct packed {
        logic z_fault;
        logic z_noop;
        logic w_fault;
        logic w_noop;
        logic no_miss;
    } mmuap_attr_type;

    // Fault behaviour of each operation under a denying zone and under a
    // clear write permit.
    function automatic mmuap_attr_type op_attr(input mmuap_op_type op);
        mmuap_attr_type a;
        a = '{z_fault: 1'b0, z_noop: 1'b0, w_fault: 1'b0, w_noop: 1'b0,
              no_miss: 1'b0};
        unique case (op)
            OP_LOAD, OP_STR_LOAD, OP_BLK_FLUSH, OP_BLK_STBACK,
            OP_IC_BLK_INVAL: a.z_fault = 1'b1;
            OP_STORE, OP_STR_STORE, OP_BLK_ZERO:
            begin
                a.z_fault = 1'b1;
                a.w_fault = 1'b1;
            end
            OP_BLK_ALLOC:
            begin
                a.z_noop = 1'b1;
                a.w_noop = 1'b1;
            end
            OP_BLK_INVAL, OP_DC_CC_INVAL: a.w_fault = 1'b1;
            OP_TOUCH, OP_TOUCH_ST:
            begin
                a.z_noop = 1'b1;
                a.no_miss = 1'b1;
            end
            OP_IC_TOUCH: a.z_noop = 1'b1;
            OP_DC_READ, OP_IC_CC_INVAL, OP_IC_READ: a.z_fault = 1'b0;
            default: a.z_fault = 1'b0;
        endcase
        return a;
    endfunction
endpackage

/* rtl/mmuap_zone_perm.sv */
// Purpose: Effective execute and write permission of one page.
// Assumes: Inputs come from logic on the same clock.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module mmuap_zone_perm
(
    input wire logic [31:0] zone_protection_reg,
    input wire logic [3:0] zone_select_field,
    input wire logic problem_state_flag,
    input wire logic execute_permit_bit,
    input wire logic write_permit_bit,
    output logic deny_all,
    output logic ex_ok,
    output logic wr_ok
);
    logic [1:0] zone_field;
    logic grant;
    logic [4:0] msb_idx;

    // Zone n sits at big-endian bits 2n..2n+1.
    assign msb_idx = 5'(31 - 2 * int'(zone_select_field));
    assign zone_field = {zone_protection_reg[msb_idx],
                         zone_protection_reg[msb_idx - 5'h01]};
    assign deny_all = problem_state_flag && zone_field == mmuap_pkg::ZONE_DENY;
    assign grant = problem_state_flag ? zone_field == mmuap_pkg::ZONE_FULL
                                      : zone_field[1];
    assign ex_ok = !deny_all && (grant || execute_permit_bit);
    assign wr_ok = !deny_all && (grant || write_permit_bit);
endmodule
`default_nettype wire

/* rtl/mmuap_id_match.sv */
// Purpose: Qualify a translation entry against the current process ID.
// Assumes: Hit means a valid entry matched the effective address.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module mmuap_id_match
(
    input wire logic entry_hit,
    input wire logic [7:0] translation_id_field,
    input wire logic [7:0] process_id,
    output logic entry_ok
);
    // A zero ID is shared by all processes.
    assign entry_ok = entry_hit && (translation_id_field == 8'h00 ||
                                    translation_id_field == process_id);
endmodule
`default_nettype wire

/* tb/mmuap_core_model.sv */
// Purpose: Core pipeline model that replays a fetch tag on execution.
// Assumes: Tags arrive with fch_done_r, one execution per run_go pulse.
// Notes: Idle tag lines show the inverse of the held tag, not zero.
`timescale 1ns/1ps
`default_nettype none
module mmuap_core_model
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic fch_done_r,
    input wire logic [1:0] fch_tag_r,
    input wire logic run_go,
    output logic exe_valid,
    output logic [1:0] exe_tag
);
    logic [1:0] held_r;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            held_r <= 2'h0;
        else if (fch_done_r)
            held_r <= fch_tag_r;
    end

    // A fetch that is never run is dropped here, so it must stay silent.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exe_valid <= 1'h0;
            exe_tag <= 2'h3;
        end
        else
        begin
            exe_valid <= run_go;
            exe_tag <= run_go ? held_r : ~held_r;
        end
    end
endmodule
`default_nettype wire

/* tb/mmu_access_protection_check_tb_top.sv */
// Purpose: Self-checking bench of the access protection checker.
// Assumes: Classic Wishbone master; core model replays fetch tags.
// Notes: Data results are one-hot {dsi, miss, noop, allow}.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
module mmu_access_protection_check_tb_top;
    localparam logic [3:0] A = 4'h1;
    localparam logic [3:0] N = 4'h2;
    localparam logic [3:0] M = 4'h4;
    localparam logic [3:0] D = 4'h8;
    localparam logic [7:0] P = 8'h34;
    int mismatches = 0;
    int num_checks = 0;
    logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, fch_tid, dat_tid;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i, fch_zone_select_field, dat_zone_select_field;
    logic fch_valid, fch_hit, fch_ex, fch_done_r, exe_valid, isi_r;
    logic itlb_miss_r, dat_valid, dat_hit, dat_wr, dat_done_r, run_go;
    logic dat_allow_r, dat_noop_r, dsi_r, dtlb_miss_r;
    logic [1:0] fch_tag_r, exe_tag;
    logic [6:0] string_byte_count;
    mmuap_pkg::mmuap_op_type dat_op;

    mmuap_check mmuap_check_i (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
        .fch_valid, .fch_hit, .fch_tid, .fch_ex, .fch_zone_select_field, .fch_done_r,
        .fch_tag_r, .exe_valid, .exe_tag, .isi_r, .itlb_miss_r, .dat_valid,
        .dat_op, .dat_hit, .dat_tid, .dat_wr, .dat_zone_select_field, .string_byte_count,
        .dat_done_r, .dat_allow_r, .dat_noop_r, .dsi_r, .dtlb_miss_r);
    mmuap_core_model mmuap_core_model_i (.sys_clk, .nrst, .fch_done_r,
        .fch_tag_r, .run_go, .exe_valid, .exe_tag);

    initial
    begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // Bus and check drivers
    // ****************************************
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, v};
        for (n = 0; n < 20 && wb_ack_o !== 1'h1; n++)
            @(posedge sys_clk);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (n == 20)
        begin
            mismatches++;
            close_out;
        end
    endtask

    task automatic d(input mmuap_pkg::mmuap_op_type op, input logic h,
        input logic [7:0] t, input logic w, input logic [3:0] z,
        input logic [3:0] e, input logic [6:0] c = 7'h01);
        @(posedge sys_clk);
        dat_valid <= 1'h1;
        dat_op <= op;
        {dat_hit, dat_tid, dat_wr, dat_zone_select_field} <= {h, t, w, z};
        string_byte_count <= c;
        @(posedge sys_clk);
        dat_valid <= 1'h0;
        #1;
        `CHK("data", {1'h1, e}, {dat_done_r, dsi_r, dtlb_miss_r, dat_noop_r,
            dat_allow_r})
    endtask

    task automatic f(input logic h, input logic ex, input logic [3:0] z,
        input logic [1:0] et, input logic run, input logic [1:0] ei);
        @(posedge sys_clk);
        {fch_valid, fch_hit, fch_tid, fch_ex, fch_zone_select_field} <= {1'h1, h, P, ex, z};
        @(posedge sys_clk);
        fch_valid <= 1'h0;
        #1;
        `CHK("fetch", {1'h1, et}, {fch_done_r, fch_tag_r})
        @(posedge sys_clk);
        run_go <= run;
        @(posedge sys_clk);
        run_go <= 1'h0;
        @(posedge sys_clk);
        #1;
        `CHK("exec", ei, {itlb_miss_r, isi_r})
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        wb(1'h0, mmuap_pkg::OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        wb(1'h1, mmuap_pkg::OFS_PID, 32'hFFFF_FF34);
        wb(1'h0, mmuap_pkg::OFS_PID, 32'h0);
        `CHK("pid", 32'h0000_0034, rd)
        wb(1'h1, mmuap_pkg::OFS_ZPR, 32'h1B00_0003);
        wb(1'h0, mmuap_pkg::OFS_ZPR, 32'h0);
        `CHK("zpr", 32'h1B00_0003, rd)
        wb(1'h1, 8'h10, 32'hFFFF_FFFF);
        wb(1'h0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask

    task automatic t_prob;
        wb(1'h1, mmuap_pkg::OFS_CTRL, 32'h6);
        d(mmuap_pkg::OP_LOAD, 1'h1, P, 1'h1, 4'h0, D);
        d(mmuap_pkg::OP_LOAD, 1'h1, 8'h00, 1'h0, 4'h1, A);
        d(mmuap_pkg::OP_LOAD, 1'h1, 8'h35, 1'h1, 4'h1, M);
        d(mmuap_pkg::OP_STORE, 1'h1, P, 1'h0, 4'h1, D);
        d(mmuap_pkg::OP_STORE, 1'h1, P, 1'h0, 4'h2, D);
        d(mmuap_pkg::OP_STORE, 1'h1, P, 1'h0, 4'h3, A);
        d(mmuap_pkg::OP_STORE, 1'h1, P, 1'h0, 4'hF, A);
        d(mmuap_pkg::OP_LOAD, 1'h1, P, 1'h1, 4'hE, D);
        d(mmuap_pkg::OP_BLK_ZERO, 1'h1, P, 1'h0, 4'h1, D);
        d(mmuap_pkg::OP_BLK_INVAL, 1'h1, P, 1'h0, 4'h1, D);
        d(mmuap_pkg::OP_BLK_INVAL, 1'h1, P, 1'h1, 4'h0, A);
        d(mmuap_pkg::OP_DC_CC_INVAL, 1'h1, P, 1'h0, 4'h1, D);
        d(mmuap_pkg::OP_BLK_FLUSH, 1'h1, P, 1'h0, 4'h1, A);
        d(mmuap_pkg::OP_BLK_FLUSH, 1'h1, P, 1'h1, 4'h0, D);
        d(mmuap_pkg::OP_BLK_STBACK, 1'h1, P, 1'h1, 4'h0, D);
        d(mmuap_pkg::OP_IC_BLK_INVAL, 1'h1, P, 1'h1, 4'h0, D);
        d(mmuap_pkg::OP_BLK_ALLOC, 1'h1, P, 1'h0, 4'h1, N);
        d(mmuap_pkg::OP_BLK_ALLOC, 1'h1, P, 1'h1, 4'h0, N);
        d(mmuap_pkg::OP_TOUCH, 1'h1, P, 1'h1, 4'h0, N);
        d(mmuap_pkg::OP_TOUCH_ST, 1'h0, P, 1'h1, 4'h1, N);
        d(mmuap_pkg::OP_IC_TOUCH, 1'h1, P, 1'h1, 4'h0, N);
        d(mmuap_pkg::OP_DC_READ, 1'h1, P, 1'h0, 4'h0, A);
        d(mmuap_pkg::OP_IC_READ, 1'h1, P, 1'h0, 4'h0, A);
        d(mmuap_pkg::OP_IC_CC_INVAL, 1'h1, P, 1'h0, 4'h0, A);
        d(mmuap_pkg::OP_IC_CC_INVAL, 1'h0, P, 1'h1, 4'h1, M);
        d(mmuap_pkg::OP_STR_STORE, 1'h0, P, 1'h0, 4'h0, N, 7'h00);
        d(mmuap_pkg::OP_STR_LOAD, 1'h0, P, 1'h0, 4'h0, A, 7'h00);
        d(mmuap_pkg::OP_STR_STORE, 1'h1, P, 1'h0, 4'h1, D, 7'h09);
    endtask

    task automatic t_super;
        wb(1'h1, mmuap_pkg::OFS_CTRL, 32'h2);
        d(mmuap_pkg::OP_LOAD, 1'h1, P, 1'h0, 4'h0, A);
        d(mmuap_pkg::OP_STORE, 1'h1, P, 1'h0, 4'h2, A);
        d(mmuap_pkg::OP_STORE, 1'h1, P, 1'h0, 4'h0, D);
        wb(1'h1, mmuap_pkg::OFS_CTRL, 32'h0);
        d(mmuap_pkg::OP_STORE, 1'h0, P, 1'h0, 4'h0, A);
    endtask

    task automatic t_fetch;
        wb(1'h1, mmuap_pkg::OFS_CTRL, 32'h5);
        f(1'h1, 1'h0, 4'h1, 2'h1, 1'h1, 2'h1);
        f(1'h1, 1'h0, 4'h1, 2'h1, 1'h0, 2'h0);
        f(1'h1, 1'h0, 4'h3, 2'h0, 1'h1, 2'h0);
        f(1'h1, 1'h1, 4'h0, 2'h1, 1'h1, 2'h1);
        f(1'h1, 1'h0, 4'h2, 2'h1, 1'h1, 2'h1);
        f(1'h0, 1'h1, 4'h1, 2'h2, 1'h1, 2'h2);
        wb(1'h1, mmuap_pkg::OFS_CTRL, 32'h1);
        f(1'h1, 1'h0, 4'h2, 2'h0, 1'h1, 2'h0);
        f(1'h1, 1'h0, 4'h1, 2'h1, 1'h1, 2'h1);
        wb(1'h1, mmuap_pkg::OFS_CTRL, 32'h6);
        f(1'h1, 1'h0, 4'h1, 2'h0, 1'h1, 2'h0);
        wb(1'h0, mmuap_pkg::OFS_STAT, 32'h0);
        `CHK("stat", 32'h0003_040C, rd)
    endtask

    initial
    begin
        nrst = 1'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        {fch_valid, fch_hit, fch_tid, fch_ex, fch_zone_select_field, run_go} = '0;
        {dat_valid, dat_hit, dat_tid, dat_wr, dat_zone_select_field} = '0;
        dat_op = mmuap_pkg::OP_LOAD;
        string_byte_count = 7'h01;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'h1;
        t_regs;
        t_prob;
        t_super;
        t_fetch;
        close_out;
    end
endmodule
`default_nettype wire
